// ==== common/imsc_pkg.sv ====
// Purpose: constants and types shared by the misc control and self-test block
// Assumes: 200 MHz system clock, host words arrive already deserialised
// Notes:
package imsc_pkg;

  // host word: bit 15 write, [14:8] byte address, [7:0] data
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } imsc_din_t;

  localparam logic [6:0] ADDR_AUX_LO  = 7'h30;
  localparam logic [6:0] ADDR_AUX_HI  = 7'h31;
  localparam logic [6:0] ADDR_PIN_LO  = 7'h32;
  localparam logic [6:0] ADDR_PIN_HI  = 7'h33;
  localparam logic [6:0] ADDR_MSC_LO  = 7'h34;
  localparam logic [6:0] ADDR_MSC_HI  = 7'h35;
  localparam logic [6:0] ADDR_SMPL_LO = 7'h36;
  localparam logic [6:0] ADDR_DIAG_LO = 7'h3C;
  localparam logic [6:0] ADDR_GLOB_LO = 7'h3E;

  localparam int MSC_DR_SEL   = 0;
  localparam int MSC_DR_POL   = 1;
  localparam int MSC_DR_EN    = 2;
  localparam int MSC_ALIGN    = 6;
  localparam int MSC_BIASCOMP = 7;
  localparam int MSC_STIM_POS = 8;
  localparam int MSC_STIM_NEG = 9;
  localparam int MSC_SELFTEST = 10;
  localparam int MSC_MEMTEST  = 11;
  localparam int GLOB_DAC_LATCH = 2;
  localparam int PIN_DIR_FOUR   = 3;
  localparam int DIAG_MEM_FAIL  = 6;
  localparam int DIAG_ST_FAIL   = 5;
  localparam int DIAG_ST_LSB    = 10;
  localparam int DAC_BITS       = 12;

  localparam logic [15:0] MSC_WR_MASK = 16'h0FC7;
  localparam logic [15:0] MSC_RESET   = 16'h0006;
  localparam logic [15:0] PIN_RESET   = 16'h0000;
  localparam logic [7:0]  SMPL_RESET  = 8'h01;
  localparam logic [11:0] DAC_RESET   = 12'h000;

  localparam int CLK_PERIOD_NS  = 5;
  localparam int DRDY_MIN_NS    = 100000;
  localparam int DRDY_MAX_NS    = 200000;
  localparam int DRDY_MIN_CYC   = (DRDY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRDY_MAX_CYC   = DRDY_MAX_NS / CLK_PERIOD_NS;

endpackage : imsc_pkg

// ==== design/imsc_drdy_pulse.sv ====
// Purpose: stretches a sample-ready strobe into a fixed-width data ready pulse
// Assumes: trigger is a one-cycle strobe on the system clock
// Notes: a trigger during an active pulse is ignored so the width never grows
`timescale 1ns/1ps
module imsc_drdy_pulse #(
  parameter int WIDTH_CYC = 20000
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // control
  input wire logic i_trigger,
  // pulse
  output logic o_active
);
  localparam int CW = $clog2(WIDTH_CYC + 1);

  // refuse widths outside the pulse window while elaborating
  if (WIDTH_CYC < imsc_pkg::DRDY_MIN_CYC || WIDTH_CYC > imsc_pkg::DRDY_MAX_CYC) begin : g_width_bad
    $error("pulse width outside the allowed window");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
    end else if (i_trigger) begin
      nxt_cnt = CW'(WIDTH_CYC);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_active = (cnt_ff != '0);

  // helper: length of the pulse just ended
  logic [CW-1:0] len_ff;
  logic [CW-1:0] nxt_len;

  always_comb begin
    nxt_len = '0;
    if (o_active) begin
      nxt_len = len_ff + CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      len_ff <= '0;
    end else begin
      len_ff <= nxt_len;
    end
  end

  chk_pulse_width: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $fell(o_active) |-> (len_ff == CW'(WIDTH_CYC)))
    else $error("data ready pulse width wrong");

  chk_pulse_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_trigger && !o_active) |=> o_active)
    else $error("data ready pulse did not start");

endmodule : imsc_drdy_pulse

// ==== design/imsc_misc_ctrl.sv ====
// Purpose: misc control, data ready, self-test, memory test and analog output latch
// Assumes: host words come from the serial front end on i_sys_clk
// Notes: line four input is a pin and is synchronised here
`timescale 1ns/1ps
module imsc_misc_ctrl #(
  parameter int DRDY_WIDTH_CYC = imsc_pkg::DRDY_MIN_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // host word port
  input wire logic i_din_valid,
  input wire imsc_pkg::imsc_din_t i_din,
  output logic [15:0] o_rd_data,
  // sample timing
  input wire logic i_sample_tick,
  input wire logic i_samples_ready,
  output logic o_sample_start,
  output logic [7:0] o_sample_period_cfg,
  // io lines
  input wire logic i_io_line_four,
  output logic o_io_line_one,
  output logic o_io_line_one_oe_n,
  output logic o_io_line_two,
  output logic o_io_line_two_oe_n,
  // test engines
  output logic o_memtest_start,
  input wire logic i_memtest_done,
  input wire logic i_memtest_fail,
  output logic o_selftest_start,
  input wire logic i_selftest_done,
  input wire logic [5:0] i_selftest_axis_fail,
  output logic o_stim_neg,
  output logic o_stim_pos,
  // compensation and analog output
  output logic o_bias_comp_en,
  output logic o_origin_align_en,
  output logic [11:0] o_dac_code
);

  logic [15:0] msc_ff, nxt_msc;
  logic [15:0] pin_ff, nxt_pin;
  logic [7:0] smpl_ff, nxt_smpl;
  logic [11:0] dac_stage_ff, nxt_dac_stage;
  logic [11:0] dac_ff, nxt_dac;
  logic [15:0] diag_ff, nxt_diag;
  logic [15:0] rd_ff, nxt_rd;
  logic mem_go_ff, nxt_mem_go, st_go_ff, nxt_st_go;
  logic smp_ff, nxt_smp;
  logic sync1_ff, sync2_ff, sync3_ff, lvl_ff, nxt_lvl;
  logic wr, ext_en, ext_rise, latch;

  function automatic logic hit(input imsc_pkg::imsc_din_t d, input logic [6:0] a);
    hit = (d.addr == a);
  endfunction : hit

  assign wr = i_din_valid && i_din.wr;
  assign latch = wr && hit(i_din, imsc_pkg::ADDR_GLOB_LO) && i_din.data[imsc_pkg::GLOB_DAC_LATCH];
  assign ext_en = !pin_ff[imsc_pkg::PIN_DIR_FOUR] && (smpl_ff == 8'h00);
  assign ext_rise = sync2_ff && sync3_ff && !lvl_ff;

  // register writes
  always_comb begin
    nxt_msc = msc_ff;
    nxt_pin = pin_ff;
    nxt_smpl = smpl_ff;
    nxt_dac_stage = dac_stage_ff;
    nxt_dac = dac_ff;
    nxt_mem_go = 1'b0;
    nxt_st_go = 1'b0;
    // completion clears first so a same-cycle write wins
    if (i_memtest_done) begin
      nxt_msc[imsc_pkg::MSC_MEMTEST] = 1'b0;
    end
    if (i_selftest_done) begin
      nxt_msc[imsc_pkg::MSC_SELFTEST] = 1'b0;
    end
    if (wr) begin
      if (hit(i_din, imsc_pkg::ADDR_MSC_LO)) begin
        nxt_msc[7:0] = i_din.data & imsc_pkg::MSC_WR_MASK[7:0];
      end else if (hit(i_din, imsc_pkg::ADDR_MSC_HI)) begin
        nxt_msc[15:8] = i_din.data & imsc_pkg::MSC_WR_MASK[15:8];
        // a start written in the completion cycle wins and launches a fresh run
        nxt_mem_go = i_din.data[imsc_pkg::MSC_MEMTEST - 8]
          && (!msc_ff[imsc_pkg::MSC_MEMTEST] || i_memtest_done);
        nxt_st_go = i_din.data[imsc_pkg::MSC_SELFTEST - 8]
          && (!msc_ff[imsc_pkg::MSC_SELFTEST] || i_selftest_done);
        if (msc_ff[imsc_pkg::MSC_MEMTEST] && !i_memtest_done) begin
          nxt_msc[imsc_pkg::MSC_MEMTEST] = 1'b1;
        end
        if (msc_ff[imsc_pkg::MSC_SELFTEST] && !i_selftest_done) begin
          nxt_msc[imsc_pkg::MSC_SELFTEST] = 1'b1;
        end
      end else if (hit(i_din, imsc_pkg::ADDR_PIN_LO)) begin
        nxt_pin[7:0] = {4'h0, i_din.data[3:0]};
      end else if (hit(i_din, imsc_pkg::ADDR_SMPL_LO)) begin
        nxt_smpl = i_din.data;
      end else if (hit(i_din, imsc_pkg::ADDR_AUX_LO)) begin
        nxt_dac_stage[7:0] = i_din.data;
      end else if (hit(i_din, imsc_pkg::ADDR_AUX_HI)) begin
        nxt_dac_stage[11:8] = i_din.data[3:0];
      end
    end
    if (latch) begin
      nxt_dac = dac_stage_ff;
    end
  end

  // diagnostic flags and read data
  always_comb begin
    nxt_diag = diag_ff;
    if (i_memtest_done) begin
      nxt_diag[imsc_pkg::DIAG_MEM_FAIL] = i_memtest_fail;
    end
    if (i_selftest_done) begin
      nxt_diag[imsc_pkg::DIAG_ST_LSB +: 6] = i_selftest_axis_fail;
      nxt_diag[imsc_pkg::DIAG_ST_FAIL] = |i_selftest_axis_fail;
    end
    nxt_rd = rd_ff;
    if (i_din_valid && !i_din.wr) begin
      if (i_din.addr[6:1] == imsc_pkg::ADDR_MSC_LO[6:1]) begin
        nxt_rd = msc_ff;
      end else if (i_din.addr[6:1] == imsc_pkg::ADDR_PIN_LO[6:1]) begin
        nxt_rd = {4'h0, lvl_ff, 3'h0, pin_ff[7:0]};
      end else if (i_din.addr[6:1] == imsc_pkg::ADDR_SMPL_LO[6:1]) begin
        nxt_rd = {8'h00, smpl_ff};
      end else if (i_din.addr[6:1] == imsc_pkg::ADDR_AUX_LO[6:1]) begin
        nxt_rd = {4'h0, dac_stage_ff};
      end else if (i_din.addr[6:1] == imsc_pkg::ADDR_DIAG_LO[6:1]) begin
        nxt_rd = diag_ff;
      end else begin
        nxt_rd = 16'h0000;
      end
    end
  end

  // external clock edge and sample start
  always_comb begin
    nxt_lvl = lvl_ff;
    if (sync2_ff == sync3_ff) begin
      nxt_lvl = sync3_ff;
    end
    nxt_smp = ext_en ? ext_rise : i_sample_tick;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      msc_ff <= imsc_pkg::MSC_RESET;
      pin_ff <= imsc_pkg::PIN_RESET;
      smpl_ff <= imsc_pkg::SMPL_RESET;
      dac_stage_ff <= imsc_pkg::DAC_RESET;
      dac_ff <= imsc_pkg::DAC_RESET;
      diag_ff <= 16'h0000;
      rd_ff <= 16'h0000;
      mem_go_ff <= 1'b0;
      st_go_ff <= 1'b0;
      smp_ff <= 1'b0;
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      msc_ff <= nxt_msc;
      pin_ff <= nxt_pin;
      smpl_ff <= nxt_smpl;
      dac_stage_ff <= nxt_dac_stage;
      dac_ff <= nxt_dac;
      diag_ff <= nxt_diag;
      rd_ff <= nxt_rd;
      mem_go_ff <= nxt_mem_go;
      st_go_ff <= nxt_st_go;
      smp_ff <= nxt_smp;
      sync1_ff <= i_io_line_four;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  // data ready pulse and pin routing
  logic drdy_active;
  logic dr_level;

  imsc_drdy_pulse #(
    .WIDTH_CYC(DRDY_WIDTH_CYC)
  ) u_drdy (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_trigger(i_samples_ready && msc_ff[imsc_pkg::MSC_DR_EN]),
    .o_active(drdy_active)
  );

  assign dr_level = drdy_active ? msc_ff[imsc_pkg::MSC_DR_POL] : !msc_ff[imsc_pkg::MSC_DR_POL];
  assign o_io_line_one = dr_level;
  assign o_io_line_two = dr_level;
  assign o_io_line_one_oe_n = !(msc_ff[imsc_pkg::MSC_DR_EN] && !msc_ff[imsc_pkg::MSC_DR_SEL]);
  assign o_io_line_two_oe_n = !(msc_ff[imsc_pkg::MSC_DR_EN] && msc_ff[imsc_pkg::MSC_DR_SEL]);

  assign o_rd_data = rd_ff;
  assign o_sample_start = smp_ff;
  assign o_sample_period_cfg = smpl_ff;
  assign o_memtest_start = mem_go_ff;
  assign o_selftest_start = st_go_ff;
  assign o_stim_neg = msc_ff[imsc_pkg::MSC_STIM_NEG];
  assign o_stim_pos = msc_ff[imsc_pkg::MSC_STIM_POS];
  assign o_bias_comp_en = msc_ff[imsc_pkg::MSC_BIASCOMP];
  assign o_origin_align_en = msc_ff[imsc_pkg::MSC_ALIGN];
  assign o_dac_code = dac_ff;

  chk_ext_edge_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (ext_en && ext_rise) |=> o_sample_start ##1 !o_sample_start)
    else $error("external edge did not start one sample");

  chk_ext_gated_off: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!ext_en && !i_sample_tick) |=> !o_sample_start)
    else $error("sample start without enabled source");

  chk_drdy_gate: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !msc_ff[imsc_pkg::MSC_DR_EN] |-> (o_io_line_one_oe_n && o_io_line_two_oe_n))
    else $error("data ready driven while disabled");

  chk_drdy_polarity: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!o_io_line_one_oe_n && $rose(drdy_active)) |-> (o_io_line_one == msc_ff[imsc_pkg::MSC_DR_POL]))
    else $error("data ready level has wrong polarity");

  chk_memtest_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_memtest_done && !(wr && hit(i_din, imsc_pkg::ADDR_MSC_HI))) |=> !msc_ff[imsc_pkg::MSC_MEMTEST])
    else $error("memory test bit not cleared");

  chk_memtest_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr && hit(i_din, imsc_pkg::ADDR_MSC_HI) && i_din.data[3] && !msc_ff[imsc_pkg::MSC_MEMTEST])
      |=> (o_memtest_start && msc_ff[imsc_pkg::MSC_MEMTEST]) ##1 !o_memtest_start)
    else $error("memory test not started");

  chk_selftest_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_selftest_done && !(wr && hit(i_din, imsc_pkg::ADDR_MSC_HI))) |=> !msc_ff[imsc_pkg::MSC_SELFTEST])
    else $error("self-test bit not cleared");

  chk_stim_follow: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (wr && hit(i_din, imsc_pkg::ADDR_MSC_HI))
      |=> (o_stim_neg == $past(i_din.data[1]) && o_stim_pos == $past(i_din.data[0])))
    else $error("stimulus bits do not follow write");

  chk_dac_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !latch |=> $stable(o_dac_code))
    else $error("analog output changed without latch");

  chk_diag_memflag: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_memtest_done |=> (diag_ff[imsc_pkg::DIAG_MEM_FAIL] == $past(i_memtest_fail)))
    else $error("memory test result not recorded");

endmodule : imsc_misc_ctrl

// ==== sim/imsc_host_model.sv ====
// Purpose: host side that sends byte writes and word reads to the control block
// Assumes: one word per strobe, read answer settled one cycle after the read edge
// Notes: word lines are inverted while idle so a stale word is never reused
`timescale 1ns/1ps
module imsc_host_model (
  // clock
  input wire logic i_sys_clk,
  // word port
  input wire logic [15:0] i_rd_data,
  output logic o_din_valid,
  output imsc_pkg::imsc_din_t o_din
);
  initial begin
    o_din_valid = 1'b0;
    o_din = '0;
  end

  task automatic send(input logic wr, input logic [6:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #1;
    o_din_valid = 1'b1;
    o_din = '{wr: wr, addr: addr, data: data};
    @(posedge i_sys_clk);
    #1;
    o_din_valid = 1'b0;
    o_din = ~o_din;
  endtask : send

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    send(1'b1, addr, data);
  endtask : wr

  task automatic rd(input logic [6:0] addr, output logic [15:0] val);
    send(1'b0, addr, 8'h00);
    @(posedge i_sys_clk);
    #1;
    val = i_rd_data;
  endtask : rd

  // stimulus step, then settle with the sensor held still
  task automatic stim_step(input logic [7:0] hi, input int settle);
    wr(imsc_pkg::ADDR_MSC_HI, hi);
    repeat (settle) @(posedge i_sys_clk);
    #1;
  endtask : stim_step
endmodule : imsc_host_model

// ==== sim/tb_imsc_misc_ctrl.sv ====
// Purpose: self-checking bench for the misc control block
// Assumes: test engines and sample sources are driven here
// Notes: expected register contents are kept in integer models
`timescale 1ns/1ps
module tb_imsc_misc_ctrl;
  localparam int W = imsc_pkg::DRDY_MIN_CYC;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_din_valid;
  imsc_pkg::imsc_din_t i_din;
  logic [15:0] o_rd_data, rv;
  logic i_sample_tick = 1'b0, i_samples_ready = 1'b0, o_sample_start;
  logic [7:0] o_sample_period_cfg;
  logic i_io_line_four = 1'b0;
  logic o_io_line_one, o_io_line_one_oe_n, o_io_line_two, o_io_line_two_oe_n;
  logic o_memtest_start, i_memtest_done = 1'b0, i_memtest_fail = 1'b0;
  logic o_selftest_start, i_selftest_done = 1'b0;
  logic [5:0] i_selftest_axis_fail = 6'h00;
  logic o_stim_neg, o_stim_pos, o_bias_comp_en, o_origin_align_en;
  logic [11:0] o_dac_code, code;
  int err_count = 0, checks = 0, seed, ctl_m = 'h0006, diag_m = 0, dac_m = 0;
  int fail_q[$];
  logic [7:0] st[4] = '{8'h00, 8'h02, 8'h01, 8'h00};

  always #2.5 i_sys_clk = ~i_sys_clk;

  imsc_host_model host (.i_sys_clk(i_sys_clk), .i_rd_data(o_rd_data), .o_din_valid(i_din_valid), .o_din(i_din));

  imsc_misc_ctrl #(.DRDY_WIDTH_CYC(W)) DUT (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_din_valid(i_din_valid), .i_din(i_din),
    .o_rd_data(o_rd_data), .i_sample_tick(i_sample_tick), .i_samples_ready(i_samples_ready),
    .o_sample_start(o_sample_start), .o_sample_period_cfg(o_sample_period_cfg),
    .i_io_line_four(i_io_line_four), .o_io_line_one(o_io_line_one), .o_io_line_one_oe_n(o_io_line_one_oe_n),
    .o_io_line_two(o_io_line_two), .o_io_line_two_oe_n(o_io_line_two_oe_n),
    .o_memtest_start(o_memtest_start), .i_memtest_done(i_memtest_done), .i_memtest_fail(i_memtest_fail),
    .o_selftest_start(o_selftest_start), .i_selftest_done(i_selftest_done),
    .i_selftest_axis_fail(i_selftest_axis_fail), .o_stim_neg(o_stim_neg), .o_stim_pos(o_stim_pos),
    .o_bias_comp_en(o_bias_comp_en), .o_origin_align_en(o_origin_align_en), .o_dac_code(o_dac_code));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [6:0] addr, input int exp);
    host.rd(addr, rv);
    chk(rv, 16'(exp));
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic drdy(input bit en, input bit sel, input bit act);
    int n;
    n = 0;
    i_samples_ready = 1'b1;
    cyc(1);
    i_samples_ready = 1'b0;
    chk({o_io_line_one_oe_n, o_io_line_two_oe_n}, !en ? 16'h3 : (sel ? 16'h2 : 16'h1));
    repeat (W + 8) begin
      if ((sel ? o_io_line_two : o_io_line_one) === act) n++;
      cyc(1);
    end
    chk(16'(n), en ? 16'(W) : 16'h0000);
  endtask : drdy

  task automatic engine(input bit mem, input logic [5:0] f);
    host.wr(imsc_pkg::ADDR_MSC_HI, mem ? 8'h08 : 8'h04);
    chk(mem ? o_memtest_start : o_selftest_start, 16'h1);
    rdc(imsc_pkg::ADDR_MSC_LO, ctl_m | (mem ? 'h0800 : 'h0400));
    fail_q.push_back(f);
    i_memtest_done = mem;
    i_selftest_done = !mem;
    i_memtest_fail = f[0];
    i_selftest_axis_fail = f;
    cyc(1);
    i_memtest_done = 1'b0;
    i_selftest_done = 1'b0;
    cyc(1);
    rdc(imsc_pkg::ADDR_MSC_LO, ctl_m);
    f = 6'(fail_q.pop_front());
    if (mem) diag_m = diag_m | (f[0] << 6);
    else diag_m = (diag_m & 'h40) | (f << 10) | ((f != 0) << 5);
    rdc(imsc_pkg::ADDR_DIAG_LO, diag_m);
  endtask : engine

  task automatic ext_edge(input int n_exp);
    int n;
    n = 0;
    i_io_line_four = 1'b1;
    repeat (12) begin
      cyc(1);
      if (o_sample_start === 1'b1) n++;
    end
    i_io_line_four = 1'b0;
    cyc(8);
    chk(16'(n), 16'(n_exp));
  endtask : ext_edge

  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    #((3 * W + 10000) * 5);
    err_count++;
    finish_test();
  end

  initial begin
    seed = 11;
    cyc(8);
    i_reset = 1'b0;
    chk({o_io_line_one_oe_n, o_io_line_one, o_io_line_two_oe_n}, 16'h1);
    rdc(imsc_pkg::ADDR_MSC_LO, ctl_m);
    rdc(imsc_pkg::ADDR_PIN_LO, 0);
    rdc(imsc_pkg::ADDR_SMPL_LO, imsc_pkg::SMPL_RESET);
    chk(o_sample_period_cfg, 16'(imsc_pkg::SMPL_RESET));
    $display("done: reset");
    repeat (4) begin
      code = 12'($random(seed));
      host.wr(imsc_pkg::ADDR_MSC_LO, code[7:0]);
      ctl_m = (ctl_m & 'hFF00) | (code[7:0] & 'hC7);
      rdc(imsc_pkg::ADDR_MSC_LO, ctl_m);
      chk({o_bias_comp_en, o_origin_align_en}, 16'(ctl_m[7:6]));
    end
    host.wr(imsc_pkg::ADDR_MSC_LO, 8'h06);
    ctl_m = 'h0006;
    foreach (st[i]) begin
      host.stim_step(st[i], 20);
      chk({o_stim_neg, o_stim_pos}, 16'(st[i][1:0]));
    end
    $display("done: control bits");
    engine(1'b0, 6'($random(seed)));
    engine(1'b1, 6'h01);
    $display("done: test engines");
    code = 12'($random(seed));
    host.wr(imsc_pkg::ADDR_AUX_LO, code[7:0]);
    host.wr(imsc_pkg::ADDR_AUX_HI, {4'hA, code[11:8]});
    rdc(imsc_pkg::ADDR_AUX_LO, code);
    cyc(2);
    chk(o_dac_code, 16'(dac_m));
    host.wr(imsc_pkg::ADDR_GLOB_LO, 8'h04);
    dac_m = code;
    cyc(1);
    chk(o_dac_code, 16'(dac_m));
    $display("done: analog code");
    drdy(1'b1, 1'b0, 1'b1);
    host.wr(imsc_pkg::ADDR_MSC_LO, 8'h05);
    drdy(1'b1, 1'b1, 1'b0);
    host.wr(imsc_pkg::ADDR_MSC_LO, 8'h02);
    drdy(1'b0, 1'b0, 1'b1);
    $display("done: data ready");
    i_sample_tick = 1'b1;
    cyc(1);
    i_sample_tick = 1'b0;
    chk(o_sample_start, 16'h1);
    ext_edge(0);
    host.wr(imsc_pkg::ADDR_SMPL_LO, 8'h00);
    chk(o_sample_period_cfg, 16'h0000);
    host.wr(imsc_pkg::ADDR_PIN_LO, 8'h08);
    rdc(imsc_pkg::ADDR_PIN_LO, 'h0008);
    ext_edge(0);
    host.wr(imsc_pkg::ADDR_PIN_LO, 8'h00);
    ext_edge(1);
    $display("done: sample clock");
    finish_test();
  end
endmodule : tb_imsc_misc_ctrl
